// ---- verif/sdsram_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ===
// Host clocks: K pair once traffic starts, C pair trailing by board skew
module sdsram_host (
   input wire logic run,
   output logic kClk,
   output logic kbClk,
   output logic cClk,
   output logic cbClk
);
   initial kClk = 1'b0;
   // 125 ns period, still until the first access may begin
   always begin
      wait (run);
      #62.5 kClk = ~kClk;
   end
   // Complements, and a 30 ns flight skew on the output pair
   assign kbClk = ~kClk;
   assign #30 cClk = kClk;
   assign cbClk = ~cClk;
endmodule
`default_nettype wire

// ---- verif/sdsram_port_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ===
// Read port timing at the pins, C pair launching, K pair in single clock mode
module sdsram_port_checker #(
   parameter int WORD_W = 18
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic singleClockMode,
   input wire logic kClk,
   input wire logic cClk,
   input wire logic read_port_select_n,
   input wire logic [WORD_W-1:0] readData,
   input wire logic readDataOe
);
   logic kP_q, cP_q, idle_q, idleOld_q;
   logic [7:0] cAge_q;
   // Launch clock and the request that the current burst answers
   wire logic launchClk = singleClockMode ? kClk : cClk;
   wire logic idleNow = singleClockMode ? idleOld_q : idle_q;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Age since the last launch rise saturates so idle stretches never wrap
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         {kP_q, cP_q, idle_q, idleOld_q, cAge_q} <= 12'hFFF;
      end else begin
         {kP_q, cP_q} <= {kClk, launchClk};
         if (kClk & ~kP_q) {idleOld_q, idle_q} <= {idle_q, read_port_select_n};
         cAge_q <= (launchClk & ~cP_q) ? 8'h00 : cAge_q + {7'h00, ~&cAge_q};
      end
   end
   property p_rst; $rose(reset_n) |-> !readDataOe; endproperty
   a_rst: assert property (p_rst) else $error("drive at reset exit");
   property p_rise; $rose(readDataOe) |-> !idleNow && cAge_q <= 8'h08; endproperty
   a_rise: assert property (p_rise) else $error("drive without read");
   property p_fall; $fell(readDataOe) |-> idleNow && cAge_q <= 8'h08; endproperty
   a_fall: assert property (p_fall) else $error("early release");
   property p_move; $changed(readData) && readDataOe |-> cAge_q <= 8'h08 || cAge_q inside {[12:21]}; endproperty
   a_move: assert property (p_move) else $error("data off launch");
   property p_ans; $rose(kClk) && !read_port_select_n && !singleClockMode |-> ##[1:16] readDataOe; endproperty
   a_ans: assert property (p_ans) else $error("read not answered");
   property p_ans1; $rose(kClk) && !read_port_select_n && singleClockMode |-> ##[1:40] readDataOe; endproperty
   a_ans1: assert property (p_ans1) else $error("single mode read not answered");
   property p_burst; $rose(readDataOe) |=> readDataOe [*8]; endproperty
   a_burst: assert property (p_burst) else $error("burst cut");
   property p_state; cAge_q == 8'h0C |-> readDataOe == !idleNow; endproperty
   a_state: assert property (p_state) else $error("drive state wrong");
   property p_hold; cAge_q >= 8'h09 && cAge_q <= 8'h0B |=> $stable(readData); endproperty
   a_hold: assert property (p_hold) else $error("word not held");
endmodule
bind sdsram_port sdsram_port_checker #(.WORD_W(WORD_W)) sdsram_port_checker_inst (.*);
`default_nettype wire

// ---- verif/sdsram_port_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ===
// Random bursts against a two-array model
module sdsram_port_tb;
   logic clk_sys = 1'b0, reset_n = 1'b0, run = 1'b0, pend = 1'b0, singleClockMode = 1'b0;
   logic write_port_select_n = 1'b1, read_port_select_n = 1'b1, kClk, kbClk, cClk, cbClk, readDataOe;
   logic [1:0] byte_lane_write_select_n = 2'h3;
   logic [3:0] addr = 4'h0;
   logic [17:0] writeData = 18'h00000, readData, exp1, mem0 [16], mem1 [16];
   logic [35:0] pair, rdQ [$];
   int err_total = 0, samples_checked = 0, seed = 2243;
   // Launch clocks follow the mode; single mode launches on the K pair
   wire logic fallClk = singleClockMode ? kbClk : cbClk;
   wire logic riseClk = singleClockMode ? kClk : cClk;
   always #2.5 clk_sys = ~clk_sys;
   sdsram_host sdsram_host_inst (.*);
   sdsram_port #(.ADDR_W(4)) sdsram_port_inst (.*);
   // Flags ride in the low bit of a word compare
   task automatic cmp(input logic [17:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [17:0] merge(input logic [17:0] old, nw, input logic [1:0] n);
      merge = old;
      for (int i = 0; i < 2; i++)
         if (!n[i]) merge[9*i+:9] = nw[9*i+:9];
   endfunction
   function automatic logic [1:0] rnd();
      rnd = 2'($random(seed));
   endfunction
   // One K period; pins move 30 ns after K rise and 27.5 ns after K-bar rise so both edges see them still
   task automatic cyc(input logic [1:0] sel, input logic [3:0] ra, wa, input logic [1:0] b0, b1);
      logic [17:0] w0, w1;
      w0 = 18'($random(seed));
      w1 = 18'($random(seed));
      {read_port_select_n, write_port_select_n, addr, writeData, byte_lane_write_select_n} = {sel, ra, w0, b0};
      @(posedge kClk);
      if (!sel[1] && !singleClockMode) rdQ.push_back({mem0[ra], mem1[ra]});
      repeat (6) @(posedge clk_sys);
      #1 {read_port_select_n, write_port_select_n, addr, writeData, byte_lane_write_select_n} = {2'h3, wa, w1, b1};
      @(posedge kbClk);
      if (!sel[0]) mem0[wa] = merge(mem0[wa], w0, b0);
      if (!sel[0]) mem1[wa] = merge(mem1[wa], w1, b1);
      repeat (6) @(posedge clk_sys);
      // Single mode bursts leave a K period later, so they queue after this check
      if (!sel[1] && singleClockMode) rdQ.push_back({mem0[ra], mem1[ra]});
      #1;
   endtask
   // Word 0 is settled by the fallClk rise (C-bar, or K-bar in single mode), word 1 by the next riseClk rise
   always @(posedge fallClk) if (run) begin
      cmp({17'h00000, readDataOe}, {17'h00000, rdQ.size() > 0});
      if (rdQ.size() > 0) begin
         pair = rdQ.pop_front();
         cmp(readData, pair[35:18]);
         {exp1, pend} = {pair[17:0], 1'b1};
      end
   end
   always @(posedge riseClk) if (pend) begin
      cmp(readData, exp1);
      pend = 1'b0;
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Fill, random mix, read-back under deselected writes, drain
   initial begin
      #11 reset_n = 1'b1;
      #15 run = 1'b1;
      for (int a = 0; a < 16; a++) cyc(2'h2, 4'h0, 4'(a), 2'h0, 2'h0);
      for (int n = 0; n < 48; n++) cyc(rnd(), 4'(n), 4'(n + 8), rnd(), rnd());
      for (int a = 0; a < 16; a++) cyc(2'h1, 4'(a), 4'(a + 8), 2'h0, 2'h0);
      repeat (2) cyc(2'h3, 4'h0, 4'h0, 2'h0, 2'h0);
      singleClockMode = 1'b1;
      for (int n = 0; n < 16; n++) cyc(rnd(), 4'(n), 4'(n + 8), rnd(), rnd());
      repeat (3) cyc(2'h3, 4'h0, 4'h0, 2'h0, 2'h0);
      finish_test();
   end
   // Hang guard, about 1.6 times the expected run
   initial begin
      #20000 err_total++;
      finish_test();
   end
endmodule
`default_nettype wire

// ---- verilog/sdsram_defs.svh ----
`ifndef SDSRAM_DEFS_SVH
`define SDSRAM_DEFS_SVH
// =====================================================================
// Geometry
`define SDSRAM_WORD_W_X18 18
`define SDSRAM_WORD_W_X36 36
`define SDSRAM_ADDR_W_X18 19
`define SDSRAM_ADDR_W_X36 18
`define SDSRAM_LANE_W 9
// =====================================================================
// Timing: link clock period in the bench, system clock period (ns)
`define SDSRAM_LINK_PERIOD_NS 125
`define SDSRAM_SYS_PERIOD_NS 5
`endif

// ---- verilog/sdsram_edge_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with rising-edge detect on the second stage only
module sdsram_edge_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut,
   output logic [WIDTH-1:0] riseOut
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] prev_q;
   logic [1:0] warm_q;
   // =====================================================================
   // Synchroniser; first stage feeds only the second
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= asyncIn;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end
   assign syncOut = sync_q;
   // Edges are ignored until the history flop holds a real sample, so a pin
   // that idles high cannot fake a rise right after reset
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         warm_q <= 2'h0;
      end else if (warm_q != 2'h3) begin
         warm_q <= warm_q + 2'h1;
      end
   end
   assign riseOut = (warm_q == 2'h3) ? (sync_q & ~prev_q) : '0;
endmodule
`default_nettype wire

// ---- verilog/sdsram_pkg.sv ----
package sdsram_pkg;
   // Edge events found on the four sampled link clocks
   typedef struct packed {
      logic kRise;
      logic kbRise;
      logic cRise;
      logic cbRise;
   } sdsram_edges_t;
   // Read burst sequencing
   typedef enum logic [1:0] {RD_IDLE, RD_WORD0, RD_WORD1} sdsram_rd_state_t;
endpackage

// ---- verilog/sdsram_port.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sdsram_defs.svh"
// How it works
// - Write data is captured on K rise and again on K-bar rise.
// - Write select sampled low on K rise starts a write.
// - Write select high deselects writes; write data is ignored.
// - Lanes with byte select high keep their stored byte.
// - Byte selects are sampled with each data word on both edges.
// - Byte select n gates the 9-bit lane n of the word.
// - Read address taken on K rise, write address on K-bar rise.
// - Address is 19 bits for x18, 18 bits for x36; one burst each.
// - Two equal arrays; each burst takes one word from each.
// - Address for a deselected port slot is disregarded.
// - Read data launched on C and C-bar rises, or K edges in single mode.
// - Read outputs are released while the read port is idle.
// - Read select sampled low on K rise starts a read.
// - On deselect, finish pending read, then release after next C rise, or K rise in single mode.
// - Each read returns exactly two words, one from each array at the same address.
// - Every access begins on a K rise.
module sdsram_port #(
   parameter bit WIDE = 1'b0,
   parameter int WORD_W = WIDE ? `SDSRAM_WORD_W_X36 : `SDSRAM_WORD_W_X18,
   parameter int ADDR_W = WIDE ? `SDSRAM_ADDR_W_X36 : `SDSRAM_ADDR_W_X18,
   parameter int LANES = WORD_W / `SDSRAM_LANE_W,
   parameter int DEPTH = 1 << ADDR_W
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic singleClockMode,
   input wire logic kClk,
   input wire logic kbClk,
   input wire logic cClk,
   input wire logic cbClk,
   input wire logic write_port_select_n,
   input wire logic read_port_select_n,
   input wire logic [LANES-1:0] byte_lane_write_select_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [WORD_W-1:0] writeData,
   output logic [WORD_W-1:0] readData,
   output logic readDataOe
);
   // =====================================================================
   // Usage limits
   // Every pin is resampled by clk_sys, so each link half period must span
   // several system cycles; this is a model of the port, not a fast path.
   // Pins must stay still for at least four system cycles around each link
   // edge, otherwise the data flops may catch a word from the other phase.
   // With the output pair skewed late, a burst leaves at the first launch
   // rise after the request is seen, inside the same K period.
   // In single clock mode the request is seen just after the K rise that
   // launches, so the burst leaves one full K period later.
   // A read and a write of one burst location in the same period are not
   // merged: word 1 of the read may show the freshly written word.
   // Memory contents are not reset; an unwritten location reads as garbage.

   // Two arrays: word 0 and word 1 of every burst location
   // No reset on purpose: clearing a whole array would cost a sweep state
   logic [WORD_W-1:0] array0 [DEPTH];
   logic [WORD_W-1:0] array1 [DEPTH];

   logic [3:0] clkSync;
   logic [3:0] clkRise;
   sdsram_pkg::sdsram_edges_t edges;
   logic [2+LANES+ADDR_W+WORD_W-1:0] pinsRaw;
   logic [2+LANES+ADDR_W+WORD_W-1:0] pinsSync;
   logic wpsN, rpsN;
   logic [LANES-1:0] bwsN;
   logic [ADDR_W-1:0] addrS;
   logic [WORD_W-1:0] dataS;
   logic launchRise, launchFall, modeS;

   // =====================================================================
   // Pin sampling
   sdsram_edge_sync #(.WIDTH(4)) uClk (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .asyncIn({cbClk, cClk, kbClk, kClk}),
      .syncOut(clkSync),
      .riseOut(clkRise)
   );
   // Data pins pass two flops too, so they stay aligned with the clock edges
   assign pinsRaw = {
      write_port_select_n,
      read_port_select_n,
      byte_lane_write_select_n,
      addr,
      writeData
   };
   sdsram_edge_sync #(.WIDTH(2+LANES+ADDR_W+WORD_W)) uPins (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .asyncIn(pinsRaw),
      .syncOut(pinsSync),
      .riseOut()
   );
   sdsram_edge_sync #(.WIDTH(1)) uMode (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .asyncIn(singleClockMode),
      .syncOut(modeS),
      .riseOut()
   );
   assign {wpsN, rpsN, bwsN, addrS, dataS} = pinsSync;
   assign edges = '{kRise: clkRise[0], kbRise: clkRise[1], cRise: clkRise[2], cbRise: clkRise[3]};
   // Output launch edges; single clock mode uses the input clock pair
   assign launchRise = modeS ? edges.kRise : edges.cRise;
   assign launchFall = modeS ? edges.kbRise : edges.cbRise;

   // Merge enabled lanes of a new word onto the stored word
   function automatic logic [WORD_W-1:0] laneMerge(input logic [WORD_W-1:0] oldW,
                                                   input logic [WORD_W-1:0] newW,
                                                   input logic [LANES-1:0] selN);
      logic [WORD_W-1:0] res;
      res = oldW;
      for (int i = 0; i < LANES; i++) begin
         if (!selN[i]) begin
            res[i*`SDSRAM_LANE_W +: `SDSRAM_LANE_W] = newW[i*`SDSRAM_LANE_W +: `SDSRAM_LANE_W];
         end
      end
      return res;
   endfunction

   // =====================================================================
   // Write path: K rise takes select and word 0, K-bar rise word 1 and address
   logic wrPend_q;
   logic [WORD_W-1:0] wrWord0_q;
   logic [LANES-1:0] wrSel0_q;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wrPend_q <= 1'b0;
         wrWord0_q <= '0;
         wrSel0_q <= '1;
      end else if (edges.kRise) begin
         wrPend_q <= !wpsN;
         if (!wpsN) begin
            wrWord0_q <= dataS;
            wrSel0_q <= bwsN;
         end
      end else if (edges.kbRise) begin
         wrPend_q <= 1'b0;
      end
   end

   // Commit both words at the K-bar rise; untouched lanes keep their bytes
   // A K-bar rise without a pending write leaves the arrays untouched
   always_ff @(posedge clk_sys) begin
      if (edges.kbRise && wrPend_q) begin
         array0[addrS] <= laneMerge(array0[addrS], wrWord0_q, wrSel0_q);
         array1[addrS] <= laneMerge(array1[addrS], dataS, bwsN);
      end
   end

   // =====================================================================
   // Read path: address taken on K rise only when read select is low
   logic rdReq_q;
   logic [ADDR_W-1:0] rdAddr_q;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdReq_q <= 1'b0;
         rdAddr_q <= '0;
      end else if (edges.kRise) begin
         rdReq_q <= !rpsN;
         if (!rpsN) begin
            rdAddr_q <= addrS;
         end
      end else if (rdReq_q && launchRise) begin
         // A launch rise without a new K rise consumes the request
         rdReq_q <= 1'b0;
      end
   end

   // Burst sequencer: word 0 on launch rise, word 1 on the complementary rise
   sdsram_pkg::sdsram_rd_state_t rdState_q;
   logic [ADDR_W-1:0] burstAddr_q;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdState_q <= sdsram_pkg::RD_IDLE;
         readData <= '0;
         readDataOe <= 1'b0;
         burstAddr_q <= '0;
      end else begin
         case (rdState_q)
            sdsram_pkg::RD_IDLE: begin
               // Outputs stay released until a request meets a launch rise
               if (launchRise) begin
                  readDataOe <= 1'b0;
                  if (rdReq_q) begin
                     readData <= array0[rdAddr_q];
                     readDataOe <= 1'b1;
                     burstAddr_q <= rdAddr_q;
                     rdState_q <= sdsram_pkg::RD_WORD0;
                  end
               end
            end
            sdsram_pkg::RD_WORD0: begin
               // Word 1 leaves on the complementary launch edge
               if (launchFall) begin
                  readData <= array1[burstAddr_q];
                  rdState_q <= sdsram_pkg::RD_WORD1;
               end
            end
            sdsram_pkg::RD_WORD1: begin
               // Pending read completes before outputs release at next launch rise
               if (launchRise) begin
                  if (rdReq_q) begin
                     readData <= array0[rdAddr_q];
                     burstAddr_q <= rdAddr_q;
                     rdState_q <= sdsram_pkg::RD_WORD0;
                  end else begin
                     readDataOe <= 1'b0;
                     rdState_q <= sdsram_pkg::RD_IDLE;
                  end
               end
            end
            default: rdState_q <= sdsram_pkg::RD_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire
